//--- ssrx_top.sv
// Notes on behaviour
// - Single-receive enable is ignored; slave reception behaves as clocked master reception.
// - Continuous enable set before low power keeps reception running in that state.
// - A finished word moves from the shift register into the receive buffer.
// - With receive interrupt enable set, the completion event wakes the chip.
// - Slave mode needs clocked mode select, port enable set and clock source cleared.
// - Ninth-bit receive enable selects 9-bit words instead of 8-bit words.
// - Words are accepted only while continuous receive enable is set.
// - Completion sets the receive flag and requests an interrupt when enabled.
// - Status read returns the received ninth bit and error flags of the word.
// - Buffer read returns the low eight data bits of the word.
// - Clearing continuous receive enable clears latched errors so reception can resume.
// - Interrupt leaves only with global and peripheral enables, bits 7 and 6.
// - The external master drives the shift clock; the device drives none.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ssrx_params.svh"
module ssrx_top
  import ssrx_pkg::*;
(
  input wire logic mclk, // System clock, 20 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic low_power, // Chip is in sleep or idle
  input wire logic shift_clock_pin_i, // Shift clock from the master
  output logic shift_clock_pin_o, // Shift clock drive, never used
  output logic shift_clock_pin_oe, // Shift clock enable, held low
  input wire logic data_pin_i, // Serial data from the master
  output logic irq, // Receive interrupt request
  output logic wake // Wake request to the core
);
  ssrx_state_t s_q;
  ssrx_state_t s_d;
  logic [1:0] pins;
  logic ck_clean;
  logic dat_clean;
  logic slave;
  logic rx_on;
  logic fall;
  logic rd_buf;
  logic rd_st;
  logic buf_full;
  logic done;
  logic ovr;
  logic [8:0] word;
  logic [3:0] last;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  ssrx_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({shift_clock_pin_i, data_pin_i}),
    .q(pins)
  );

  assign ck_clean = pins[1];
  assign dat_clean = pins[0];

  always_comb
  begin
    s_d = s_q;
    done = 1'b0;
    ovr = 1'b0;
    slave = s_q.txsta[`SSRX_B_SYNC] & s_q.ctl[`SSRX_B_SERIAL_PORT_ENABLE] & ~s_q.txsta[`SSRX_B_CLOCK_SOURCE_SELECT];
    // Single-receive enable takes no part here
    rx_on = slave & s_q.ctl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE];
    // Data are taken on the falling shift clock edge, as in master reception
    fall = s_q.ck_prev & ~ck_clean;
    rd_buf = rd & hit(addr, `SSRX_A_RXBUF);
    rd_st = rd & hit(addr, `SSRX_A_IRQST);
    // A read in the same cycle frees the buffer for the new word
    buf_full = s_q.flag & ~rd_buf;
    last = s_q.ctl[`SSRX_B_RX9] ? `SSRX_LAST9 : `SSRX_LAST8;
    word = s_q.sh;
    word[s_q.cnt] = dat_clean;
    s_d.ck_prev = ck_clean;
    s_d.ck_o = 1'b0;
    s_d.ck_oe = 1'b0;
    if (rd_buf)
    begin
      s_d.flag = 1'b0;
    end
    if (!s_q.ctl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE])
    begin
      s_d.overrun_error_flag = 1'b0;
      s_d.framing_error_flag = 1'b0;
    end
    case (s_q.rx)
      SSRX_OFF:
      begin
        s_d.cnt = 4'h0;
        if (rx_on)
        begin
          s_d.rx = SSRX_SHIFT;
        end
      end
      SSRX_SHIFT:
      begin
        if (!rx_on)
        begin
          s_d.rx = SSRX_OFF;
          s_d.cnt = 4'h0;
        end
        else if (fall)
        begin
          // Low power does not gate the shifter
          s_d.sh = word;
          if (s_q.cnt == last)
          begin
            done = 1'b1;
            s_d.cnt = 4'h0;
            if (buf_full)
            begin
              ovr = 1'b1;
              s_d.overrun_error_flag = 1'b1;
              s_d.rx = SSRX_HALT;
            end
            else
            begin
              s_d.rxbuf = word[7:0];
              s_d.received_ninth_bit = s_q.ctl[`SSRX_B_RX9] & word[8];
              s_d.flag = 1'b1;
            end
          end
          else
          begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
      end
      SSRX_HALT:
      begin
        // Overrun stops the shifter until the enable is dropped
        if (!s_q.ctl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE])
        begin
          s_d.rx = SSRX_OFF;
        end
      end
      default:
      begin
        s_d.rx = SSRX_OFF;
      end
    endcase
    if (wr)
    begin
      case (addr)
        `SSRX_A_RCSTA: s_d.ctl = wdata & `SSRX_WM_RCSTA;
        `SSRX_A_TXSTA: s_d.txsta = wdata & `SSRX_WM_TXSTA;
        `SSRX_A_BAUD: s_d.baud = wdata & `SSRX_WM_BAUD;
        `SSRX_A_INTCTL: s_d.intctl = wdata;
        `SSRX_A_IRQMSK: s_d.irq_msk = wdata[1:0];
        default: s_d.irq_msk = s_q.irq_msk;
      endcase
    end
    // Event set wins over the read that clears
    s_d.irq_st = (rd_st ? 2'b00 : s_q.irq_st) | {ovr, done};
    s_d.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `SSRX_A_RCSTA: s_d.rdata = {s_q.ctl[7:3], s_q.framing_error_flag, s_q.overrun_error_flag, s_q.received_ninth_bit};
        `SSRX_A_RXBUF: s_d.rdata = s_q.rxbuf;
        `SSRX_A_TXSTA: s_d.rdata = s_q.txsta;
        `SSRX_A_BAUD:
        begin
          s_d.rdata = s_q.baud;
          s_d.rdata[`SSRX_B_RCIDL] = (s_q.rx != SSRX_SHIFT) || (s_q.cnt == 4'h0);
        end
        `SSRX_A_INTCTL: s_d.rdata = s_q.intctl;
        `SSRX_A_IRQST: s_d.rdata = {6'h00, s_q.irq_st};
        `SSRX_A_IRQMSK: s_d.rdata = {6'h00, s_q.irq_msk};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Driven from next state so the pin tracks the status register exactly
    s_d.irq = s_d.intctl[`SSRX_B_GIE] & s_d.intctl[`SSRX_B_PERIPHERAL_INTERRUPT_ENABLE]
              & (|(s_d.irq_st & s_d.irq_msk));
    // Wake bypasses the global gates: the core must run to take the vector
    s_d.wake = low_power & s_d.flag & s_d.irq_msk[`SSRX_B_EVWORD];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign wake = s_q.wake;
  assign shift_clock_pin_o = s_q.ck_o;
  assign shift_clock_pin_oe = s_q.ck_oe;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  slave_gate_a: assert property ((s_q.rx == SSRX_SHIFT && !rx_on) |=> s_q.rx == SSRX_OFF)
    else $error("shifter kept running outside slave receive");
  enable_only_a: assert property ((s_q.rx == SSRX_OFF && !rx_on) |=> s_q.rx == SSRX_OFF)
    else $error("receiver started without continuous enable");
  buffer_load_a: assert property ((done && !ovr) |=> s_q.rxbuf == $past(word[7:0]) && s_q.flag)
    else $error("finished word not moved into buffer");
  word_len_a: assert property (done |-> s_q.cnt == (s_q.ctl[`SSRX_B_RX9] ? 4'h8 : 4'h7))
    else $error("word length does not follow ninth-bit enable");
  flag_irq_a: assert property ((done && !ovr && s_q.irq_msk[0] && s_q.intctl[7] && s_q.intctl[6]
      && !wr) |=> s_q.flag && irq)
    else $error("completion did not raise flag and interrupt");
  overrun_keep_a: assert property (ovr |=> s_q.overrun_error_flag && $stable(s_q.rxbuf))
    else $error("overrun lost the buffered word");
  err_clear_a: assert property (!s_q.ctl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE] |=> !s_q.overrun_error_flag && !s_q.framing_error_flag)
    else $error("errors survive a cleared receive enable");
  irq_gate_a: assert property (irq |-> s_q.intctl[7] && s_q.intctl[6])
    else $error("interrupt without global and peripheral enables");
  wake_src_a: assert property (wake |-> s_q.flag && s_q.irq_msk[0])
    else $error("wake without enabled receive flag");
  status_read_a: assert property ((rd && hit(addr, `SSRX_A_RCSTA)) |=> rdata[0] == $past(s_q.received_ninth_bit)
      && rdata[1] == $past(s_q.overrun_error_flag))
    else $error("status read lost ninth bit or error");
  buf_read_a: assert property (rd_buf |=> rdata == $past(s_q.rxbuf))
    else $error("buffer read returned wrong data");
  no_clock_a: assert property (!shift_clock_pin_oe)
    else $error("device drove the shift clock");
endmodule
`default_nettype wire

//--- ssrx_params.svh
`ifndef SSRX_PARAMS_SVH
`define SSRX_PARAMS_SVH
`define SSRX_A_RCSTA 4'h0
`define SSRX_A_RXBUF 4'h1
`define SSRX_A_TXSTA 4'h2
`define SSRX_A_BAUD 4'h3
`define SSRX_A_INTCTL 4'h4
`define SSRX_A_IRQST 4'h5
`define SSRX_A_IRQMSK 4'h6
`define SSRX_B_SERIAL_PORT_ENABLE 7
`define SSRX_B_RX9 6
`define SSRX_B_CONTINUOUS_RECEIVE_ENABLE 4
`define SSRX_B_FRAMING_ERROR_FLAG 2
`define SSRX_B_OVERRUN_ERROR_FLAG 1
`define SSRX_B_RECEIVED_NINTH_BIT 0
`define SSRX_B_CLOCK_SOURCE_SELECT 7
`define SSRX_B_SYNC 4
`define SSRX_B_RCIDL 6
`define SSRX_B_GIE 7
`define SSRX_B_PERIPHERAL_INTERRUPT_ENABLE 6
`define SSRX_B_EVWORD 0
`define SSRX_B_EVOVR 1
`define SSRX_WM_RCSTA 8'hF8
`define SSRX_WM_TXSTA 8'hFD
`define SSRX_WM_BAUD 8'hBF
`define SSRX_RST_BYTE 8'h00
`define SSRX_LAST8 4'h7
`define SSRX_LAST9 4'h8
`endif

//--- ssrx_pkg.sv
`default_nettype none
package ssrx_pkg;
  typedef enum logic [1:0] {
    SSRX_OFF = 2'b00,
    SSRX_SHIFT = 2'b01,
    SSRX_HALT = 2'b10
  } ssrx_rx_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] txsta;
    logic [7:0] baud;
    logic [7:0] intctl;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic [7:0] rxbuf;
    logic received_ninth_bit;
    logic flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic [8:0] sh;
    logic [3:0] cnt;
    ssrx_rx_t rx;
    logic ck_prev;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic ck_o;
    logic ck_oe;
  } ssrx_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] q;
  } ssrx_sync_t;
endpackage
`default_nettype wire

//--- ssrx_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssrx_sync
  import ssrx_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [1:0] d, // Raw pin levels
  output logic [1:0] q // Filtered levels
);
  ssrx_sync_t s_q;
  ssrx_sync_t s_d;

  // A change counts only once the second and third stage agree
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
      begin
        s_d.q[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;
endmodule
`default_nettype wire

//--- ssrx_master.sv
`timescale 1ns/10ps
`default_nettype none
module ssrx_master (
  output logic sck, // Shift clock, idle low
  output logic sdo // Serial data, LSB first
);
  initial
  begin
    sck = 1'b0;
    sdo = 1'b0;
  end
  // Edges sit off the 50 ns grid so the filter never races mclk
  task automatic send(input logic [8:0] w, input logic nine);
    #13;
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      sdo = w[i];
      sck = 1'b1;
      #200 sck = 1'b0;
      #200;
    end
    // Released line must not keep showing the last bit
    sdo = ~sdo;
  endtask
endmodule
`default_nettype wire

//--- ssrx_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssrx_params.svh"
module ssrx_tb;
  logic mclk, rst_n, wr, rd, low_power, irq, wake, sck, sdo, ck_o, ck_oe;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int n_fail = 0;
  int total_checks = 0;
  localparam logic [15:0] OFF_CFG [4] = '{16'h1080, 16'h9090, 16'h1010, 16'h0090};

  ssrx_master m (.sck(sck), .sdo(sdo));
  ssrx_top DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .low_power(low_power), .shift_clock_pin_i(sck),
    .shift_clock_pin_o(ck_o), .shift_clock_pin_oe(ck_oe), .data_pin_i(sdo),
    .irq(irq), .wake(wake));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic see(ref logic s, input logic e);
    @(negedge mclk);
    chk(8'(s), 8'(e));
    @(posedge mclk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
    @(posedge mclk);
  endtask

  task automatic wait_out(input logic use_wake);
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(negedge mclk);
      if ((use_wake ? wake : irq) === 1'b1)
        break;
    end
    if (i == 60)
    begin
      n_fail++;
      test_done();
    end
    @(posedge mclk);
  endtask

  task automatic t_regs();
    see(ck_oe, 1'b0);
    see(ck_o, 1'b0);
    rchk(`SSRX_A_BAUD, 8'h40);
    for (int a = 0; a < 7; a++)
      if (a != 3) rchk(4'(a), 8'h00);
    rchk(4'hF, 8'h00);
    wreg(4'hF, 8'hFF);
    wreg(`SSRX_A_BAUD, 8'hFF);
    rchk(`SSRX_A_BAUD, 8'hFF);
    wreg(`SSRX_A_TXSTA, 8'hFF);
    rchk(`SSRX_A_TXSTA, `SSRX_WM_TXSTA);
    $display("t_regs done");
  endtask

  task automatic t_byte8();
    wreg(`SSRX_A_TXSTA, 8'h10);
    wreg(`SSRX_A_INTCTL, 8'hC0);
    wreg(`SSRX_A_IRQMSK, 8'h01);
    wreg(`SSRX_A_RCSTA, 8'hB0);
    m.send(9'h0A5, 1'b0);
    wait_out(1'b0);
    rchk(`SSRX_A_RCSTA, 8'hB0);
    rchk(`SSRX_A_RXBUF, 8'hA5);
    rchk(`SSRX_A_IRQST, 8'h01);
    see(irq, 1'b0);
    $display("t_byte8 done");
  endtask

  task automatic t_nine();
    wreg(`SSRX_A_RCSTA, 8'hD0);
    m.send(9'h15A, 1'b1);
    wait_out(1'b0);
    rchk(`SSRX_A_RCSTA, 8'hD1);
    rchk(`SSRX_A_RXBUF, 8'h5A);
    rchk(`SSRX_A_IRQST, 8'h01);
    $display("t_nine done");
  endtask

  task automatic t_ovr();
    wreg(`SSRX_A_RCSTA, 8'h90);
    m.send(9'h011, 1'b0);
    m.send(9'h022, 1'b0);
    repeat (10) @(posedge mclk);
    rchk(`SSRX_A_RCSTA, 8'h92);
    rchk(`SSRX_A_RXBUF, 8'h11);
    rchk(`SSRX_A_IRQST, 8'h03);
    m.send(9'h033, 1'b0);
    repeat (10) @(posedge mclk);
    see(irq, 1'b0);
    wreg(`SSRX_A_RCSTA, 8'h80);
    rchk(`SSRX_A_RCSTA, 8'h80);
    wreg(`SSRX_A_RCSTA, 8'h90);
    m.send(9'h044, 1'b0);
    wait_out(1'b0);
    rchk(`SSRX_A_RXBUF, 8'h44);
    rchk(`SSRX_A_IRQST, 8'h01);
    $display("t_ovr done");
  endtask

  task automatic t_off();
    for (int k = 0; k < 4; k++)
    begin
      wreg(`SSRX_A_TXSTA, OFF_CFG[k][15:8]);
      wreg(`SSRX_A_RCSTA, OFF_CFG[k][7:0]);
      m.send(9'h077, 1'b0);
      repeat (10) @(posedge mclk);
      see(irq, 1'b0);
      rchk(`SSRX_A_IRQST, 8'h00);
    end
    wreg(`SSRX_A_TXSTA, 8'h10);
    $display("t_off done");
  endtask

  task automatic t_sleep();
    wreg(`SSRX_A_INTCTL, 8'h00);
    low_power <= 1'b1;
    wreg(`SSRX_A_RCSTA, 8'h90);
    m.send(9'h03C, 1'b0);
    wait_out(1'b1);
    see(irq, 1'b0);
    wreg(`SSRX_A_INTCTL, 8'h40);
    see(irq, 1'b0);
    wreg(`SSRX_A_INTCTL, 8'h80);
    see(irq, 1'b0);
    wreg(`SSRX_A_INTCTL, 8'hC0);
    see(irq, 1'b1);
    rchk(`SSRX_A_RXBUF, 8'h3C);
    see(wake, 1'b0);
    low_power <= 1'b0;
    rchk(`SSRX_A_IRQST, 8'h01);
    $display("t_sleep done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    low_power = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_byte8();
    t_nine();
    t_ovr();
    t_off();
    t_sleep();
    test_done();
  end
endmodule
`default_nettype wire
